//--- scpd_top.v
// Channel control, thermal latch, error flags and serial register access
`timescale 1ns/1ps
`include "scpd_defs.vh"

// How it works
// - Each channel-on bit turns its channel off at 0, on at 1, and reads back as stored.
// - With the combine select at 0 a channel is requested on if its input pin or its on bit is high.
// - With the combine select at 1 a channel is requested on only while both its pin and on bit are high.
// - Writing 1 to the clear-thermal-latch bit clears every thermal latch, writing 0 leaves them alone.
// - An over-temperature indication forces its channel off through a latch kept until cleared.
// - Each channel error flag is latched until shifted out in a diagnosis word.
// - The thermal part of an error flag stays set until the clear command, not cleared by a diagnosis read.
// - Off channels report error 0; on channels report 1 for current limit, short to ground or overheat.
// - The bypass monitor bit reads 1 for a high drain-source voltage on the selected channel, else 0.
// - One selected channel's sense signal is routed to the sense pin, or the pin is disabled.
// - Each error flag is the OR of the thermal flag gated by the channel request and the latched over-load signal.
// - Latched over-load flags clear on the third serial clock rising edge of a diagnosis word.
module scpd_top #(
  parameter NCH = `SCPD_NCH
) (
  input  wire           i_clk_sys,
  input  wire           i_rst_b,
  input  wire           i_stage_rst_b,
  input  wire           i_sclk,
  input  wire           i_cs_b,
  input  wire           i_sdi,
  input  wire [NCH-1:0] i_in_pin,
  input  wire [NCH-1:0] i_over_temp,
  input  wire [NCH-1:0] i_over_load,
  input  wire [NCH-1:0] i_vds_high,
  output reg            o_sdo,
  output reg            o_sdo_oe_b,
  output reg  [NCH-1:0] o_gate_on,
  output reg            o_sense_en,
  output reg  [2:0]     o_sense_sel
);

  wire [3*NCH+2:0] raw_w;
  wire [3*NCH+2:0] syn_w;
  wire             sclk_s;
  wire             cs_b_s;
  wire             sdi_s;
  wire [NCH-1:0]   in_s;
  wire [NCH-1:0]   ot_s;
  wire [NCH-1:0]   ol_s;

  wire             cs_act_s;

  // Select travels inverted so the synchroniser's zero reset reads as deselected, not as a frame start
  assign raw_w = {i_sclk, ~i_cs_b, i_sdi, i_in_pin, i_over_temp, i_over_load};
  assign {sclk_s, cs_act_s, sdi_s, in_s, ot_s, ol_s} = syn_w;
  assign cs_b_s = ~cs_act_s;

  // The vds compare is a level read once per frame, so it gets its own stage chain
  wire [NCH-1:0] vds_s;

  scpd_sync3 #(.WIDTH(3*NCH+3)) u_sync_pins (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_async   (raw_w),
    .o_sync    (syn_w)
  );

  scpd_sync3 #(.WIDTH(NCH)) u_sync_vds (
    .i_clk_sys (i_clk_sys),
    .i_rst_b   (i_rst_b),
    .i_async   (i_vds_high),
    .o_sync    (vds_s)
  );

  reg  [NCH-1:0]           on_q;
  reg                      pwm_q;
  reg                      ctl_q;
  reg  [2:0]               sel_q;
  reg  [NCH-1:0]           ot_q;
  reg  [NCH-1:0]           ol_q;
  reg                      sclk_q;
  reg                      cs_b_q;
  reg  [`SCPD_FRAME_BITS-1:0] rx_q;
  reg  [`SCPD_FRAME_BITS-1:0] tx_q;
  reg  [`SCPD_CNT_W-1:0]   cnt_q;
  reg  [1:0]               rd_adr_q;
  reg                      diag_frame_q;
  reg                      soft_rst_q;

  wire sclk_rise = sclk_s & ~sclk_q;
  wire sclk_fall = ~sclk_s & sclk_q;
  wire cs_fall   = ~cs_b_s & cs_b_q;
  wire cs_rise   = cs_b_s & ~cs_b_q;
  wire frame_end = cs_rise & (cnt_q == `SCPD_CNT_FULL);

  wire                    cmd_wr  = rx_q[`SCPD_CMD_WR_BIT];
  wire [1:0]              cmd_adr = rx_q[`SCPD_CMD_ADR_HI:`SCPD_CMD_ADR_LO];
  wire [`SCPD_CMD_DAT_HI:0] cmd_dat = rx_q[`SCPD_CMD_DAT_HI:0];

  wire wr_switch = frame_end & cmd_wr & (cmd_adr == `SCPD_ADR_SWITCH);
  wire wr_hwcfg  = frame_end & cmd_wr & (cmd_adr == `SCPD_ADR_HWCFG);
  wire wr_sense  = frame_end & cmd_wr & (cmd_adr == `SCPD_ADR_SENSE);
  wire ctl_cmd   = wr_hwcfg & cmd_dat[`SCPD_HW_CTL];
  wire rst_cmd   = wr_hwcfg & cmd_dat[`SCPD_HW_RST];

  // Combined request per channel
  wire [NCH-1:0] req_w = pwm_q ? (in_s & on_q) : (in_s | on_q);
  wire [NCH-1:0] gate_w = req_w & ~ot_q;
  wire [NCH-1:0] err_w  = (ot_q & req_w) | ol_q;

  wire           sel_valid = (sel_q <= `SCPD_SENSE_MAXCH);
  // Shift rather than index so a rest code never reaches past the channel range
  wire [NCH-1:0] vds_sel_w = vds_s >> sel_q;
  wire           bypass_w  = sel_valid & vds_sel_w[0];

  reg  [`SCPD_FRAME_BITS-1:0] resp_w;

  always @* begin
    if (rd_adr_q == `SCPD_ADR_SWITCH) begin
      resp_w = {3'h0, on_q};
    end else if (rd_adr_q == `SCPD_ADR_HWCFG) begin
      resp_w = {5'h00, bypass_w, pwm_q, ctl_q};
    end else if (rd_adr_q == `SCPD_ADR_SENSE) begin
      resp_w = {5'h00, sel_q};
    end else begin
      resp_w = {3'h0, err_w};
    end
  end

  // Thermal latch lives on the power-stage reset so it survives a logic reset
  always @(posedge i_clk_sys) begin
    if (!i_stage_rst_b) begin
      ot_q <= {NCH{1'b0}};
    end else begin
      ot_q <= ot_s | (ot_q & {NCH{~ctl_cmd}});
    end
  end

  // Over-load part of the error flag; a new event wins over the read clear
  always @(posedge i_clk_sys) begin
    if (!i_rst_b || soft_rst_q) begin
      ol_q <= {NCH{1'b0}};
    end else begin
      if (diag_frame_q && sclk_rise && cnt_q == `SCPD_CNT_OLCLR) begin
        ol_q <= ol_s & gate_w;
      end else begin
        ol_q <= ol_q | (ol_s & gate_w);
      end
    end
  end

  // Register bank
  always @(posedge i_clk_sys) begin
    if (!i_rst_b || soft_rst_q) begin
      on_q  <= `SCPD_SWITCH_RST;
      pwm_q <= 1'b0;
      ctl_q <= 1'b0;
      sel_q <= `SCPD_SENSE_RST;
    end else begin
      if (wr_switch) begin
        on_q <= cmd_dat[NCH-1:0];
      end
      if (wr_hwcfg) begin
        pwm_q <= cmd_dat[`SCPD_HW_PWM];
        ctl_q <= cmd_dat[`SCPD_HW_CTL];
      end
      if (wr_sense) begin
        sel_q <= cmd_dat[2:0];
      end
    end
  end

  // Soft reset from the reset command takes effect one cycle after the frame
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= rst_cmd;
    end
  end

  // Serial shifter: sample on rising SCLK, shift out on falling SCLK
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      sclk_q       <= 1'b0;
      cs_b_q       <= 1'b1;
      rx_q         <= {`SCPD_FRAME_BITS{1'b0}};
      tx_q         <= {`SCPD_FRAME_BITS{1'b0}};
      cnt_q        <= {`SCPD_CNT_W{1'b0}};
      rd_adr_q     <= `SCPD_ADR_DIAG;
      diag_frame_q <= 1'b0;
      o_sdo        <= 1'b0;
      o_sdo_oe_b   <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      cs_b_q <= cs_b_s;
      if (cs_fall) begin
        tx_q         <= resp_w;
        o_sdo        <= resp_w[`SCPD_FRAME_BITS-1];
        o_sdo_oe_b   <= 1'b0;
        cnt_q        <= {`SCPD_CNT_W{1'b0}};
        diag_frame_q <= (rd_adr_q == `SCPD_ADR_DIAG);
      end else if (cs_b_s) begin
        o_sdo_oe_b   <= 1'b1;
        diag_frame_q <= 1'b0;
        if (frame_end) begin
          // A read names the register for the next frame; writes return to diagnosis
          rd_adr_q <= cmd_wr ? `SCPD_ADR_DIAG : cmd_adr;
        end
      end else begin
        if (sclk_rise && cnt_q != `SCPD_CNT_FULL) begin
          rx_q  <= {rx_q[`SCPD_FRAME_BITS-2:0], sdi_s};
          cnt_q <= cnt_q + 4'h1;
        end
        if (sclk_fall) begin
          tx_q  <= {tx_q[`SCPD_FRAME_BITS-2:0], 1'b0};
          o_sdo <= tx_q[`SCPD_FRAME_BITS-2];
        end
      end
      if (soft_rst_q) begin
        rd_adr_q <= `SCPD_ADR_DIAG;
      end
    end
  end

  // Gate and sense outputs; a rest code or an out-of-range code disables sense
  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_gate_on   <= {NCH{1'b0}};
      o_sense_en  <= 1'b0;
      o_sense_sel <= `SCPD_SENSE_RST;
    end else begin
      o_gate_on   <= gate_w;
      o_sense_en  <= sel_valid;
      o_sense_sel <= sel_q;
    end
  end

endmodule // scpd_top

//--- scpd_defs.vh
// Constants for the switch channel protection and diagnosis block
`ifndef SCPD_DEFS_VH
`define SCPD_DEFS_VH

`define SCPD_NCH          5
`define SCPD_FRAME_BITS   8
`define SCPD_CNT_W        4
`define SCPD_CNT_FULL     4'h8
`define SCPD_CNT_OLCLR    4'h2

// Command byte fields
`define SCPD_CMD_WR_BIT   7
`define SCPD_CMD_ADR_HI   6
`define SCPD_CMD_ADR_LO   5
`define SCPD_CMD_DAT_HI   4

// Register addresses
`define SCPD_ADR_SWITCH   2'h0
`define SCPD_ADR_HWCFG    2'h1
`define SCPD_ADR_SENSE    2'h2
`define SCPD_ADR_DIAG     2'h3

// hardware_config_reg fields
`define SCPD_HW_RST       4
`define SCPD_HW_BYPASS    2
`define SCPD_HW_PWM       1
`define SCPD_HW_CTL       0

// Sense select codes
`define SCPD_SENSE_OFF    3'h7
`define SCPD_SENSE_MAXCH  3'h4

// Reset values
`define SCPD_SWITCH_RST   5'h00
`define SCPD_SENSE_RST    3'h7

`endif

//--- scpd_sync3.v
// Three-stage input synchroniser that updates once the last two stages agree
`timescale 1ns/1ps

module scpd_sync3 #(
  parameter WIDTH = 1
) (
  input  wire             i_clk_sys,
  input  wire             i_rst_b,
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  integer         k;

  always @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      meta_q <= {WIDTH{1'b0}};
      s2_q   <= {WIDTH{1'b0}};
      s3_q   <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
      for (k = 0; k < WIDTH; k = k + 1) begin
        if (s2_q[k] == s3_q[k]) begin
          o_sync[k] <= s3_q[k];
        end
      end
    end
  end

endmodule // scpd_sync3

//--- scpd_top_properties.sv
// Port-level assertions for the channel protection and diagnosis block
`timescale 1ns/1ps
module scpd_top_properties #(
  parameter NCH = 5
) (
  input wire logic           i_clk_sys,
  input wire logic           i_rst_b,
  input wire logic           i_stage_rst_b,
  input wire logic           i_sclk,
  input wire logic           i_cs_b,
  input wire logic           i_sdi,
  input wire logic [NCH-1:0] i_in_pin,
  input wire logic [NCH-1:0] i_over_temp,
  input wire logic [NCH-1:0] i_over_load,
  input wire logic [NCH-1:0] i_vds_high,
  input wire logic           o_sdo,
  input wire logic           o_sdo_oe_b,
  input wire logic [NCH-1:0] o_gate_on,
  input wire logic           o_sense_en,
  input wire logic [2:0]     o_sense_sel
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  a_reset_gates: assert property (disable iff (1'b0) !i_rst_b |=> o_gate_on == 0 && o_sdo_oe_b)
    else $error("outputs active in reset");
  a_reset_sense: assert property (disable iff (1'b0) !i_rst_b |=> o_sense_sel == 3'h7 && !o_sense_en)
    else $error("sense not off in reset");
  a_sense_code: assert property (o_sense_en == (o_sense_sel < 3'h5))
    else $error("sense enable wrong");
  // Eight cycles covers the three-stage sync, the latch and the gate register
  a_thermal_off: assert property ($stable(i_over_temp) [*8] |-> (o_gate_on & i_over_temp) == 0)
    else $error("hot channel on");
  a_oe_fall: assert property ($fell(o_sdo_oe_b) |-> !$past(i_cs_b, 2))
    else $error("sdo driven unselected");
  a_oe_rise: assert property ($rose(o_sdo_oe_b) |-> $past(i_cs_b, 2))
    else $error("sdo released selected");
  a_idle_release: assert property (i_cs_b [*8] |-> o_sdo_oe_b)
    else $error("sdo held while idle");
  a_sel_frame_end: assert property ($changed(o_sense_sel) |-> $past(i_cs_b, 2))
    else $error("sense select mid-frame");
  cover property ($fell(o_sdo_oe_b));
  cover property (o_sense_en);
  cover property (i_over_temp != 0 && (o_gate_on & i_over_temp) == 0);
endmodule // scpd_top_properties

bind scpd_top scpd_top_properties #(.NCH(NCH)) scpd_top_properties_inst (.*);

//--- scpd_spi_master.sv
// Microcontroller-side serial master model sending mode-0 frames
`timescale 1ns/1ps
module scpd_spi_master (
  output logic      o_sclk,
  output logic      o_cs_b,
  output logic      o_sdi,
  input  wire logic i_sdo
);
  initial begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_sdi  = 1'b0;
  end
  // Clock stands low between frames; released data is inverted so stale bits never look valid
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int nb);
    rx = 8'h00;
    o_cs_b = 1'b0;
    #125;
    for (int i = 7; i > 7 - nb; i--) begin
      o_sdi = tx[i];
      #62.5 o_sclk = 1'b1;
      rx = {rx[6:0], i_sdo};
      #62.5 o_sclk = 1'b0;
    end
    #62.5 o_cs_b = 1'b1;
    o_sdi = ~o_sdi;
    #250;
  endtask
endmodule // scpd_spi_master

//--- testbench.sv
// Self-checking bench for the channel protection and diagnosis block
`timescale 1ns/1ps
module testbench;
  logic       clk, rst_b, stage_b, sclk, cs_b, sdi, sdo, oe_b, sen, pwm;
  logic [4:0] in, ot, ol, vds, gate, on, tl;
  logic [2:0] sel;
  logic [7:0] rx;
  int         fails, compares;
  scpd_top scpd_top_inst (.i_clk_sys(clk), .i_rst_b(rst_b), .i_stage_rst_b(stage_b), .i_sclk(sclk),
    .i_cs_b(cs_b), .i_sdi(sdi), .i_in_pin(in), .i_over_temp(ot), .i_over_load(ol), .i_vds_high(vds),
    .o_sdo(sdo), .o_sdo_oe_b(oe_b), .o_gate_on(gate), .o_sense_en(sen), .o_sense_sel(sel));
  // Released data line reads as pulled high
  scpd_spi_master scpd_spi_master_inst (.o_sclk(sclk), .o_cs_b(cs_b), .o_sdi(sdi), .i_sdo(oe_b | sdo));
  function automatic logic [4:0] req();
    req = pwm ? in & on : in | on;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic w8();
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic fr(input logic [7:0] c);
    scpd_spi_master_inst.xfer(c, rx, 8);
    @(posedge clk) #1;
  endtask
  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    fails++;
    finish_test();
  end
  initial begin
    {rst_b, stage_b, in, ot, ol, vds, on, tl, pwm} = 0;
    fails = 0;
    compares = 0;
    void'($urandom(32'h7E1B));
    repeat (12) @(posedge clk);
    #1 {rst_b, stage_b} = 2'b11;
    w8;
    for (int i = 0; i < 4; i++) begin
      on = 5'($urandom);
      in = 5'($urandom);
      pwm = i[0];
      fr({3'b100, on});
      fr({6'b101000, pwm, 1'b0});
      fr(8'h00);
      fr(8'h00);
      chk(rx, {3'b0, on});
      w8;
      chk(gate, req());
    end
    $display("switch test done");
    for (int s = 0; s < 8; s++) begin
      vds = 5'($urandom);
      fr(8'hC0 | 8'(s));
      fr(8'h20);
      fr(8'h20);
      chk({sen, sel}, {s < 5, 3'(s)});
      chk(rx, {5'b0, s < 5 ? vds[s] : 1'b0, pwm, 1'b0});
    end
    $display("sense test done");
    {on, in, pwm} = {5'h1F, 5'h1F, 1'b0};
    fr(8'h9F);
    fr(8'hA0);
    ot = 5'h04;
    w8;
    w8;
    {ot, tl} = {5'h00, 5'h04};
    w8;
    chk(gate, req() & ~tl);
    // A logic reset alone and a clear bit of 0 must both leave the thermal latch standing
    rst_b = 0;
    {on, pwm} = 0;
    repeat (12) @(posedge clk);
    #1 rst_b = 1;
    w8;
    fr(8'hA0);
    chk(gate, req() & ~tl);
    on = 5'h1F;
    fr(8'h9F);
    fr(8'h60);
    fr(8'h60);
    chk(rx, {3'b0, tl & req()});
    fr(8'h60);
    chk(rx, {3'b0, tl & req()});
    fr(8'hA1);
    tl = 0;
    w8;
    chk(gate, req());
    $display("thermal test done");
    on = 5'h1E;
    fr({3'b100, on});
    in = 5'h1E;
    w8;
    ol = 5'h03;
    w8;
    ol = 0;
    fr(8'h60);
    chk(rx, 8'h02);
    fr(8'h61);
    chk(rx, 8'h00);
    // A seven-edge frame must be dropped; taken, it would land as a write of all channels off
    scpd_spi_master_inst.xfer(8'h00, rx, 7);
    fr(8'h00);
    fr(8'h00);
    chk(rx, {3'b0, on});
    // The reset command returns the on bits to their reset value
    fr(8'hB0);
    on = 0;
    fr(8'h00);
    fr(8'h00);
    chk(rx, {3'b0, on});
    $display("overload test done");
    finish_test();
  end
endmodule // testbench
